/* core/ifs_fetch_seq.sv */
// Fetch cycle sequencer: time states one to three and pulses one to three.
// Assumes the memory control returns its read strobe as a one-cycle pulse,
// synchronous to i_ref_clk, some 500 to 520 ns after the launch pulse.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Time state one sets cycle-complete flag
// - Pulse one only when all qualifiers true
// - Qualifiers: run, memory quiescent, cycle complete
// - Pulse one with entry sets fetch, clears others
// - Entry needs no interrupt, tape, data break
// - Pulse one launches memory read cycle
// - Pulse one loads memory address register
// - Delayed copy of pulse one 100 ns later
// - Fetch state asserts counter-step request
// - Pulse one moves state one to two
// - State two gates address into adder
// - Carry-in when step, state two, memory allowed
// - Carry enters low bit, ripples upward
// - Memory strobe clears memory-quiescent flag
// - Pulse two loads incremented program counter
// - Pulse two clears instruction register unless indirect, execute or second execute
// - Pulse two moves state two to three
// - State three gates memory onto bus
// - Pulse three 300 ns (three cycles) after pulse two
// - Pulse three loads buffer unless executing
// - Pulse three loads instruction register fields
// - Pulse three in fetch clears skip flags
module ifs_fetch_seq
    import ifs_pkg::*;
#(
    parameter int W = IFS_WORD_W,                 // Word width
    parameter int TP1_DLY = IFS_TP1_DLY_CYC,      // Pulse one delay in cycles
    parameter int TP3_DLY = IFS_TP3_DLY_CYC       // Pulse two to three in cycles
) (
    input wire logic i_ref_clk,                   // 10 MHz clock
    input wire logic i_srst,                      // Synchronous reset, high
    input wire logic i_run,                       // Run flag
    input wire logic i_cycle_start,               // Start a fetch cycle
    input wire ifs_pend_t i_pend,                 // Pending break requests
    input wire logic i_memory_allow_flag,         // Memory allowed
    input wire logic i_bus_inhibit,               // Inhibit of memory-to-bus
    input wire logic [W-1:0] i_fetch_addr,        // Address for the fetch
    input wire logic i_memory_read_strobe,        // Read strobe from memory
    input wire logic [W-1:0] i_mem_data,          // Word read from memory
    output logic o_timing_pulse_one,              // Pulse one
    output logic o_timing_pulse_two,              // Pulse two
    output logic o_timing_pulse_three,            // Pulse three
    output logic o_delayed_pulse_one,             // Pulse one, delayed
    output logic o_time_state_one,                // Time state one
    output logic o_time_state_two,                // Time state two
    output logic o_time_state_three,              // Time state three
    output logic o_memory_cycle_launch,           // Start memory read
    output logic o_cycle_done,                    // Cycle-complete flag
    output logic o_mem_idle,                      // Memory-quiescent flag
    output ifs_major_t o_major,                   // Major state flags
    output logic o_buffered_fetch_state,          // Buffered fetch
    output logic o_counter_step_request,          // Counter step request
    output logic o_low_bit_carry_in,              // Carry insert
    output logic o_adder_gate,                    // Address gated to adder
    output logic o_memory_to_bus_gate,            // Memory onto bus
    output logic [W-1:0] o_memory_address_register, // Address register
    output logic [W-1:0] o_program_counter,       // Program counter
    output logic [W-1:0] o_memory_buffer_register, // Buffer register
    output logic [W-1:0] o_instruction_register,  // Instruction register
    output logic o_aux_flag,                      // Auxiliary toggle flag
    output logic o_skip_flag                      // Skip flag
);
    // Phase and flags
    ifs_phase_t phase_q;                 // Current phase
    logic cycle_done_q;                  // Cycle complete
    logic mem_idle_q;                    // Memory quiescent
    ifs_major_t major_q;                 // Major states
    logic fetch_b_q;                     // Buffered fetch copy
    logic [IFS_CNT_W-1:0] d1_cnt_q;      // Pulse one delay count
    logic d1_busy_q;                     // Delay line running
    logic [IFS_CNT_W-1:0] d3_cnt_q;      // Pulse two to three count
    logic d3_busy_q;                     // Waiting for pulse three
    logic tp1_q, tp2_q, tp3_q, tp1d_q;   // Registered pulses
    logic launch_q;                      // Registered launch
    logic [W-1:0] ma_q, pc_q, mb_q, ir_q; // Data registers
    logic aux_q, skip_q;                 // Skip flags
    logic step_q, carry_q, gate_q, bus_q; // Registered level outputs
    logic [W-1:0] sum;                   // Adder result
    logic tp1_fire;                      // Pulse one condition
    logic tp3_fire;                      // Pulse three condition
    logic fetch_entry_condition;         // Fetch may be entered
    logic counter_step_request;          // Step request level

    // Counter done test, used by both delays
    function automatic logic cnt_done(input logic [IFS_CNT_W-1:0] c, input int n);
        return c == IFS_CNT_W'(n - 1);
    endfunction

    // Pulse one gate: every qualifier at once
    assign tp1_fire = i_run & mem_idle_q & cycle_done_q & (phase_q == IFS_PH_TS1);
    assign fetch_entry_condition = ~(i_pend.interrupt | i_pend.tape_break
                                     | i_pend.data_break);
    assign counter_step_request = major_q.fetch;
    assign tp3_fire = d3_busy_q & cnt_done(d3_cnt_q, TP3_DLY);

    // Adder always sees the address; only its carry-in is gated in state two
    ifs_adder #(
        .W(W)
    ) u_adder (
        .i_a(ma_q),
        .i_carry_in(counter_step_request & (phase_q == IFS_PH_TS2) & i_memory_allow_flag),
        .o_sum(sum),
        .o_carry_out()
    );

    // Time state sequence, binary-coded in the two-bit phase enum
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            phase_q <= IFS_PH_DONE;
        end else begin
            case (phase_q)
                IFS_PH_DONE: begin
                    if (i_cycle_start) begin
                        phase_q <= IFS_PH_TS1;
                    end
                end
                IFS_PH_TS1: begin
                    if (tp1_fire) begin
                        phase_q <= IFS_PH_TS2;
                    end
                end
                IFS_PH_TS2: begin
                    if (i_memory_read_strobe) begin
                        phase_q <= IFS_PH_TS3;
                    end
                end
                IFS_PH_TS3: begin
                    if (tp3_fire) begin
                        phase_q <= IFS_PH_DONE; // Later states live elsewhere
                    end
                end
                default: phase_q <= IFS_PH_DONE;
            endcase
        end
    end

    // Cycle-complete flag: set in state one, consumed by pulse one
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cycle_done_q <= 1'b0;
        end else if (phase_q == IFS_PH_TS1 && !cycle_done_q) begin
            cycle_done_q <= 1'b1;
        end else if (tp1_fire) begin
            cycle_done_q <= 1'b0;
        end
    end

    // Memory-quiescent flag: strobe clears it, end of cycle restores it
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            mem_idle_q <= 1'b1;
        end else if (i_memory_read_strobe) begin
            mem_idle_q <= 1'b0;
        end else if (tp3_fire) begin
            mem_idle_q <= 1'b1; // Read half done; stands in for memory done
        end
    end

    // Major states: pulse one with entry picks fetch alone
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            major_q <= '0;
            fetch_b_q <= 1'b0;
        end else if (tp1_fire && fetch_entry_condition) begin
            major_q <= '0;
            major_q.fetch <= 1'b1;
            fetch_b_q <= 1'b1;
        end else if (tp1_fire) begin
            major_q <= '0; // Break or interrupt owns this cycle
            fetch_b_q <= 1'b0;
        end
    end

    // Pulse strobes, one cycle each
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            tp1_q <= 1'b0;
            tp2_q <= 1'b0;
            tp3_q <= 1'b0;
            launch_q <= 1'b0;
        end else begin
            tp1_q <= tp1_fire;
            launch_q <= tp1_fire;
            tp2_q <= i_memory_read_strobe && phase_q == IFS_PH_TS2;
            tp3_q <= tp3_fire;
        end
    end

    // Delay line copy of pulse one
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            d1_busy_q <= 1'b0;
            d1_cnt_q <= '0;
            tp1d_q <= 1'b0;
        end else begin
            tp1d_q <= d1_busy_q & cnt_done(d1_cnt_q, TP1_DLY);
            if (tp1_fire) begin
                d1_busy_q <= 1'b1;
                d1_cnt_q <= '0;
            end else if (d1_busy_q && cnt_done(d1_cnt_q, TP1_DLY)) begin
                d1_busy_q <= 1'b0;
            end else if (d1_busy_q) begin
                d1_cnt_q <= d1_cnt_q + 1'b1;
            end
        end
    end

    // Pulse two to pulse three timer; pulse three is registered so it
    // lands on the count that matches the printed delay
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            d3_busy_q <= 1'b0;
            d3_cnt_q <= '0;
        end else if (i_memory_read_strobe && phase_q == IFS_PH_TS2) begin
            d3_busy_q <= 1'b1;
            d3_cnt_q <= '0;
        end else if (tp3_fire) begin
            d3_busy_q <= 1'b0;
        end else if (d3_busy_q) begin
            d3_cnt_q <= d3_cnt_q + 1'b1;
        end
    end

    // Address register loaded by pulse one
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ma_q <= IFS_WORD_ZERO;
        end else if (tp1_fire) begin
            ma_q <= i_fetch_addr;
        end
    end

    // Program counter takes the stepped address on pulse two
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pc_q <= IFS_WORD_ZERO;
        end else if (tp2_q && counter_step_request) begin
            pc_q <= sum_q;
        end
    end

    // Adder result held for pulse two; carry only while state two stands
    logic [W-1:0] sum_q; // Latched stepped value
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sum_q <= IFS_WORD_ZERO;
        end else if (phase_q == IFS_PH_TS2) begin
            sum_q <= sum;
        end
    end

    // Buffer register loaded on pulse three unless executing
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            mb_q <= IFS_WORD_ZERO;
        end else if (tp3_fire && !major_q.execute) begin
            mb_q <= i_mem_data;
        end
    end

    // Instruction register: cleared on pulse two, filled on pulse three
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ir_q <= IFS_WORD_ZERO;
        end else if (tp3_fire && fetch_b_q) begin
            ir_q[W-1:IFS_IR_HI_LSB] <= i_mem_data[W-1:IFS_IR_HI_LSB];
            ir_q[IFS_IR_HI_LSB-1:0] <= i_mem_data[IFS_IR_HI_LSB-1:0];
        end else if (i_memory_read_strobe && phase_q == IFS_PH_TS2
                     && !major_q.indirect_state && !major_q.execute
                     && !major_q.second_exec_state) begin
            ir_q <= IFS_WORD_ZERO;
        end
    end

    // Skip flags cleared by pulse three in fetch
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            aux_q <= 1'b0;
            skip_q <= 1'b0;
        end else if (tp3_fire && major_q.fetch) begin
            aux_q <= 1'b0;
            skip_q <= 1'b0;
        end
    end

    // Level gates, registered so outputs come from flip-flops
    // Costs one cycle of lag against the state they follow
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            step_q <= 1'b0;
            carry_q <= 1'b0;
            gate_q <= 1'b0;
            bus_q <= 1'b0;
        end else begin
            step_q <= counter_step_request;
            gate_q <= counter_step_request && phase_q == IFS_PH_TS2;
            carry_q <= counter_step_request && phase_q == IFS_PH_TS2
                       && i_memory_allow_flag;
            bus_q <= phase_q == IFS_PH_TS3 && !i_pend.interrupt
                     && i_memory_allow_flag && !i_bus_inhibit;
        end
    end

    // Outputs
    assign o_timing_pulse_one = tp1_q;
    assign o_timing_pulse_two = tp2_q;
    assign o_timing_pulse_three = tp3_q;
    assign o_delayed_pulse_one = tp1d_q;
    assign o_memory_cycle_launch = launch_q;
    assign o_cycle_done = cycle_done_q;
    assign o_mem_idle = mem_idle_q;
    assign o_major = major_q;
    assign o_buffered_fetch_state = fetch_b_q;
    assign o_counter_step_request = step_q;
    assign o_low_bit_carry_in = carry_q;
    assign o_adder_gate = gate_q;
    assign o_memory_to_bus_gate = bus_q;
    assign o_memory_address_register = ma_q;
    assign o_program_counter = pc_q;
    assign o_memory_buffer_register = mb_q;
    assign o_instruction_register = ir_q;
    assign o_aux_flag = aux_q;
    assign o_skip_flag = skip_q;

    // Time states decoded from the phase flop (one-hot view)
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_time_state_one <= 1'b0;
            o_time_state_two <= 1'b0;
            o_time_state_three <= 1'b0;
        end else begin
            o_time_state_one <= phase_q == IFS_PH_TS1;
            o_time_state_two <= phase_q == IFS_PH_TS2;
            o_time_state_three <= phase_q == IFS_PH_TS3;
        end
    end
endmodule // ifs_fetch_seq
`default_nettype wire

/* common/ifs_pkg.sv */
// Package for the instruction fetch sequencer: widths, timing and carriers.
// Assumes a single 10 MHz clock domain shared by every user.
package ifs_pkg;
    localparam int IFS_WORD_W = 12;               // Machine word width
    localparam int IFS_CLK_NS = 100;              // Clock period in ns
    localparam int IFS_TP1_DLY_NS = 100;          // Delay line after pulse one
    localparam int IFS_TP3_DLY_NS = 350;          // Pulse two to pulse three
    // Longest-time figures round down, never below one cycle
    localparam int IFS_TP1_DLY_CYC =
        (IFS_TP1_DLY_NS / IFS_CLK_NS) < 1 ? 1 : (IFS_TP1_DLY_NS / IFS_CLK_NS);
    localparam int IFS_TP3_DLY_CYC =
        (IFS_TP3_DLY_NS / IFS_CLK_NS) < 1 ? 1 : (IFS_TP3_DLY_NS / IFS_CLK_NS);
    localparam int IFS_CNT_W = 4;                 // Delay counter width
    localparam logic [IFS_WORD_W-1:0] IFS_WORD_ZERO = 12'h000; // Cleared word
    localparam logic [IFS_WORD_W-1:0] IFS_WORD_ONE = 12'h001;  // Low-order carry weight
    localparam int IFS_IR_HI_LSB = 4;             // Low edge of field 0-7 in [11:0]

    // Sequencer phase
    typedef enum logic [1:0] {
        IFS_PH_TS1,
        IFS_PH_TS2,
        IFS_PH_TS3,
        IFS_PH_DONE
    } ifs_phase_t;

    // Pending requests that block fetch entry
    typedef struct packed {
        logic interrupt;      // Interrupt pending
        logic tape_break;     // Tape break request pending
        logic data_break;     // Three-cycle data break pending
    } ifs_pend_t;

    // Major state flags
    typedef struct packed {
        logic fetch;          // Fetch
        logic indirect_state; // Indirect (indirect_state)
        logic execute;        // Execute
        logic second_exec_state; // Second execute
    } ifs_major_t;
endpackage : ifs_pkg

/* core/ifs_adder.sv */
// Twelve-bit adder used to step the program counter.
// Assumes bit 11 of the printed order is the low-order bit, index 0 here.
`timescale 1ns/1ps
`default_nettype none
module ifs_adder
    import ifs_pkg::*;
#(
    parameter int W = IFS_WORD_W // Word width
) (
    input wire logic [W-1:0] i_a,        // Operand gated from the address
    input wire logic i_carry_in,         // Carry at the low-order end
    output logic [W-1:0] o_sum,          // Sum
    output logic o_carry_out             // Carry out of the top bit
);
    // Ripple carry: a one already in a sum bit gives zero and a carry up
    always_comb begin
        logic c;
        c = i_carry_in;
        for (int k = 0; k < W; k++) begin
            o_sum[k] = i_a[k] ^ c;
            c = i_a[k] & c;
        end
        o_carry_out = c;
    end
endmodule // ifs_adder
`default_nettype wire

/* verification/ifs_fetch_seq_asserts.sv */
// Checker for the fetch sequencer: pulse, state and gate relations.
// Assumes binding to ifs_fetch_seq, one clock, synchronous high reset.
`timescale 1ns/1ps
`default_nettype none
module ifs_fetch_seq_asserts
    import ifs_pkg::*;
#(
    parameter int TP3_DLY = IFS_TP3_DLY_CYC // Pulse two to three in cycles
) (
    input wire logic i_ref_clk, // Clock
    input wire logic i_srst, // Reset
    input wire logic i_run, // Run flag
    input wire ifs_pend_t i_pend, // Pending breaks
    input wire logic i_memory_allow_flag, // Memory allowed
    input wire logic i_bus_inhibit, // Bus inhibit
    input wire logic i_memory_read_strobe, // Read strobe
    input wire logic o_timing_pulse_one, // Pulse one
    input wire logic o_timing_pulse_two, // Pulse two
    input wire logic o_timing_pulse_three, // Pulse three
    input wire logic o_delayed_pulse_one, // Delayed pulse one
    input wire logic o_time_state_one, // State one
    input wire logic o_time_state_two, // State two
    input wire logic o_time_state_three, // State three
    input wire logic o_memory_cycle_launch, // Launch
    input wire logic o_cycle_done, // Cycle complete
    input wire logic o_mem_idle, // Memory quiescent
    input wire ifs_major_t o_major, // Major states
    input wire logic o_counter_step_request, // Step request
    input wire logic o_low_bit_carry_in, // Carry insert
    input wire logic o_memory_to_bus_gate, // Memory onto bus
    input wire logic o_aux_flag, // Auxiliary flag
    input wire logic o_skip_flag // Skip flag
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    logic [3:0] gap_q; // Cycles since pulse two, saturating
    // Count from pulse two so pulse three's distance is a plain compare
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) gap_q <= 4'h0;
        else if (o_timing_pulse_two) gap_q <= 4'h1;
        else if (gap_q != 4'h0 && gap_q != 4'hF) gap_q <= gap_q + 4'h1;
    end
    // Strobe makes pulse two, then state three follows
    sequence s_tp2_then_ts3;
        o_timing_pulse_two ##[1:2] o_time_state_three;
    endsequence
    a_tp1_qualified: assert property (o_timing_pulse_one |->
        $past(i_run && o_mem_idle && o_cycle_done)) else $error("pulse one unqualified");
    a_tp1_launch: assert property (o_timing_pulse_one |-> o_memory_cycle_launch)
        else $error("no launch with pulse one");
    a_tp1_fetch_set: assert property (o_timing_pulse_one && i_pend == 3'b000 |->
        ##[0:1] o_major == 4'h8) else $error("fetch state not entered");
    a_tp1_delay_copy: assert property (o_timing_pulse_one |=> o_delayed_pulse_one)
        else $error("delayed pulse missing");
    a_tp1_state_step: assert property (o_timing_pulse_one |->
        ##[0:1] (o_time_state_two && !o_time_state_one)) else $error("state two not entered");
    a_step_while_fetch: assert property (o_major.fetch && $past(o_major.fetch) |->
        o_counter_step_request) else $error("step request missing");
    a_carry_cause: assert property (o_low_bit_carry_in |->
        o_counter_step_request && $past(i_memory_allow_flag)) else $error("carry without cause");
    a_strobe_tp2: assert property (i_memory_read_strobe && o_time_state_two |=>
        s_tp2_then_ts3) else $error("strobe did not give pulse two");
    a_strobe_idle: assert property (i_memory_read_strobe |=> !o_mem_idle)
        else $error("memory idle not cleared");
    a_tp3_distance: assert property (o_timing_pulse_three |-> gap_q == 4'(TP3_DLY))
        else $error("pulse three misplaced");
    a_tp3_skips: assert property (o_timing_pulse_three |-> !o_skip_flag && !o_aux_flag)
        else $error("skip flags not clear");
    a_bus_gate_cause: assert property (o_memory_to_bus_gate |->
        $past(i_memory_allow_flag && !i_bus_inhibit && !i_pend.interrupt))
        else $error("bus gate without cause");
endmodule // ifs_fetch_seq_asserts
bind ifs_fetch_seq ifs_fetch_seq_asserts #(.TP3_DLY(TP3_DLY)) u_chk (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_run(i_run), .i_pend(i_pend),
    .i_memory_allow_flag(i_memory_allow_flag), .i_bus_inhibit(i_bus_inhibit),
    .i_memory_read_strobe(i_memory_read_strobe), .o_timing_pulse_one(o_timing_pulse_one),
    .o_timing_pulse_two(o_timing_pulse_two), .o_timing_pulse_three(o_timing_pulse_three),
    .o_delayed_pulse_one(o_delayed_pulse_one), .o_time_state_one(o_time_state_one),
    .o_time_state_two(o_time_state_two), .o_time_state_three(o_time_state_three),
    .o_memory_cycle_launch(o_memory_cycle_launch), .o_cycle_done(o_cycle_done),
    .o_mem_idle(o_mem_idle), .o_major(o_major), .o_aux_flag(o_aux_flag),
    .o_counter_step_request(o_counter_step_request), .o_skip_flag(o_skip_flag),
    .o_low_bit_carry_in(o_low_bit_carry_in), .o_memory_to_bus_gate(o_memory_to_bus_gate));
`default_nettype wire

/* verification/ifs_mem_model.sv */
// Memory control model: answers each launch with a strobe and a word.
// Assumes the launch is a one-cycle pulse on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module ifs_mem_model (
    input wire logic i_ref_clk, // Clock
    input wire logic i_srst, // Reset
    input wire logic i_launch, // Launch pulse
    input wire logic [3:0] i_lat, // Strobe latency in cycles
    input wire logic [11:0] i_word, // Stored word
    output logic o_strobe, // Read strobe, one cycle
    output logic [11:0] o_data // Read data
);
    logic [3:0] cnt_q; // Cycles left to strobe
    logic [2:0] hold_q; // Cycles data stays valid
    // Latency counts cycles from launch to strobe; 5 gives 500 ns
    always_ff @(posedge i_ref_clk) begin
        o_strobe <= 1'b0;
        if (i_srst) begin
            cnt_q <= 4'h0;
            hold_q <= 3'h0;
        end else if (i_launch) cnt_q <= i_lat - 4'h1;
        else if (cnt_q > 4'h1) cnt_q <= cnt_q - 4'h1;
        else if (cnt_q == 4'h1) begin
            cnt_q <= 4'h0;
            o_strobe <= 1'b1;
            hold_q <= 3'h6;
        end else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    end
    // Outside the valid window show the inverse, never a stale word
    assign o_data = (o_strobe || hold_q != 3'h0) ? i_word : ~i_word;
endmodule // ifs_mem_model
`default_nettype wire

/* verification/ifs_fetch_seq_tb.sv */
// Testbench for the fetch sequencer with a memory control model.
// Assumes default delay parameters and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module ifs_fetch_seq_tb;
    import ifs_pkg::*;
    logic i_ref_clk = 1'b0; // Clock
    logic i_srst = 1'b1; // Reset, held at start
    logic run = 1'b1; // Run flag
    logic start = 1'b0; // Cycle start
    ifs_pend_t pend = 3'b000; // Pending breaks
    logic allow = 1'b1; // Memory allowed
    logic inh = 1'b0; // Bus inhibit
    logic [11:0] addr = 12'h000; // Fetch address
    logic [11:0] word = 12'h000; // Word in memory
    logic [3:0] lat = 4'h5; // Memory latency
    wire logic strobe, launch, tp1, tp3, idle, gate, skip, aux, fb, ag;
    wire ifs_major_t major;
    wire logic [11:0] mdata, mar, pc, mb, ir;
    int fails = 0;
    int samples_checked = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    ifs_fetch_seq dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_run(run),
        .i_cycle_start(start), .i_pend(pend), .i_memory_allow_flag(allow),
        .i_bus_inhibit(inh), .i_fetch_addr(addr), .i_memory_read_strobe(strobe),
        .i_mem_data(mdata), .o_timing_pulse_one(tp1), .o_timing_pulse_two(),
        .o_timing_pulse_three(tp3), .o_delayed_pulse_one(), .o_time_state_one(),
        .o_time_state_two(), .o_time_state_three(), .o_memory_cycle_launch(launch),
        .o_cycle_done(), .o_mem_idle(idle), .o_major(major), .o_buffered_fetch_state(fb),
        .o_counter_step_request(), .o_low_bit_carry_in(), .o_adder_gate(ag),
        .o_memory_to_bus_gate(gate), .o_memory_address_register(mar),
        .o_program_counter(pc), .o_memory_buffer_register(mb),
        .o_instruction_register(ir), .o_aux_flag(aux), .o_skip_flag(skip));
    ifs_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_launch(launch),
        .i_lat(lat), .i_word(word), .o_strobe(strobe), .o_data(mdata));
    // Compare one word, count and report
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge i_ref_clk);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_srst <= 1'b0;
    endtask
    // One fetch; run held low until the loop count n reaches s, then every result judged
    task automatic run_fetch(input logic [11:0] a, input logic [11:0] w,
                             input logic [3:0] l, input int s);
        int n;
        logic gseen;
        logic aseen;
        logic early;
        logic [11:0] pc0;
        n = 0;
        gseen = 1'b0;
        aseen = 1'b0;
        early = 1'b0;
        pc0 = pc;
        @(posedge i_ref_clk);
        addr <= a;
        word <= w;
        lat <= l;
        run <= (s == 0);
        start <= 1'b1;
        @(posedge i_ref_clk);
        start <= 1'b0;
        while (tp3 !== 1'b1 && n < 80) begin
            @(posedge i_ref_clk);
            n++;
            if (n == s) run <= 1'b1;
            @(negedge i_ref_clk);
            if (gate === 1'b1) gseen = 1'b1;
            if (ag === 1'b1) aseen = 1'b1;
            if (tp1 === 1'b1 && n <= s) early = 1'b1;
        end
        chk({11'h0, n < 80}, 12'h001);
        chk({11'h0, early}, 12'h000);
        chk(mar, a);
        chk(pc, pend != 3'b000 ? pc0 : a + {11'h0, allow});
        chk(mb, w);
        chk(ir, pend != 3'b000 ? 12'h000 : w);
        chk({8'h0, major}, pend != 3'b000 ? 12'h000 : 12'h008);
        chk({10'h0, skip, aux}, 12'h000);
        chk({11'h0, gseen}, {11'h0, allow & ~inh & ~pend.interrupt});
        chk({10'h0, fb, aseen}, pend != 3'b000 ? 12'h000 : 12'h003);
        @(posedge i_ref_clk); // Hand back on a rising edge
    endtask
    task automatic t_reset_values;
        chk({11'h0, idle}, 12'h001);
        chk(pc, 12'h000);
        chk(ir, 12'h000);
    endtask
    // Each pending request alone blocks fetch entry; reset between
    task automatic t_pend_blocks;
        for (int k = 0; k < 3; k++) begin
            pend <= ifs_pend_t'(3'b001 << k);
            run_fetch(12'h123, 12'hA5C, 4'h5, 0);
            do_reset();
        end
        pend <= 3'b000;
    endtask
    task automatic t_carry_ripple;
        run_fetch(12'h0FF, 12'h5A3, 4'h5, 0);
        run_fetch(12'hFFF, 12'h3C6, 4'h5, 0);
    endtask
    task automatic t_gate_off;
        inh <= 1'b1;
        run_fetch(12'h7FE, 12'h0F0, 4'h5, 0);
        inh <= 1'b0;
    endtask
    task automatic t_no_allow;
        allow <= 1'b0;
        run_fetch(12'h456, 12'h9E1, 4'h5, 0);
        allow <= 1'b1;
    endtask
    task automatic t_run_stall;
        run_fetch(12'h010, 12'h777, 4'h5, 12);
    endtask
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        @(posedge i_ref_clk);
        t_reset_values();
        t_carry_ripple();
        t_gate_off();
        t_pend_blocks();
        t_no_allow();
        t_run_stall();
        complete_run();
    end
    // Whole run is some 140 cycles; cut off far beyond that
    initial begin
        #400000;
        fails++;
        complete_run();
    end
endmodule // ifs_fetch_seq_tb
`default_nettype wire
